// File: hdl/mbf_pkg.sv
package mbf_pkg;

  // Function codes
  localparam logic [7:0] FN_RD_HR     = 8'h03;
  localparam logic [7:0] FN_WR_REG    = 8'h06;
  localparam logic [7:0] FN_WR_COILS  = 8'h0f;
  localparam logic [7:0] FN_WR_REGS   = 8'h10;
  localparam logic [7:0] EXC_FLAG     = 8'h80;

  // Exception codes
  localparam logic [7:0] EX_NONE      = 8'h00;
  localparam logic [7:0] EX_FUNC      = 8'h01;
  localparam logic [7:0] EX_ADDR      = 8'h02;
  localparam logic [7:0] EX_VALUE     = 8'h03;

  // Addressing and limits
  localparam logic [7:0]  BCAST_ADDR  = 8'h00;
  localparam logic [16:0] HR_COUNT    = 17'h02710;
  localparam logic [15:0] MAX_REGS    = 16'h000a;
  localparam logic [16:0] COIL_COUNT  = 17'h00020;
  localparam logic [16:0] PNU_SCALE   = 17'h0000a;
  localparam logic [5:0]  BUF_DEPTH   = 6'h20;

  // Frame layout
  localparam logic [5:0]  MIN_FRAME   = 6'h04;
  localparam logic [8:0]  FIX_LEN     = 9'h008;
  localparam logic [8:0]  VAR_LEN     = 9'h009;
  localparam logic [5:0]  ECHO_LEN    = 6'h06;
  localparam logic [5:0]  EXC_LEN     = 6'h03;
  localparam logic [5:0]  RD_HDR      = 6'h03;
  localparam logic [4:0]  DATA_POS    = 5'h07;
  localparam logic [4:0]  RD_POS      = 5'h03;

  // CRC
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;

  // Command word fields
  localparam logic [15:0] CW_RESET_VAL = 16'h0000;
  localparam int CW_DCB    = 2;
  localparam int CW_COAST  = 3;
  localparam int CW_QSTOP  = 4;
  localparam int CW_HOLD   = 5;
  localparam int CW_START  = 6;
  localparam int CW_RESET  = 7;
  localparam int CW_JOG    = 8;
  localparam int CW_RAMP2  = 9;
  localparam int CW_VALID  = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY2 = 12;
  localparam int CW_SETUP  = 13;
  localparam int CW_REV    = 15;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CHECK = 3'h1,
    ST_EXEC  = 3'h2,
    ST_RDWT  = 3'h3,
    ST_PREP  = 3'h4,
    ST_SEND  = 3'h5
  } mbf_state_e;

endpackage

// File: hdl/mbf_crc16.sv
module mbf_crc16
  import mbf_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Byte stream
  input  wire logic        clear_i,
  input  wire logic        valid_i,
  input  wire logic [7:0]  data_i,
  // Result
  output logic      [15:0] crc_o
);

  logic [15:0] next_crc;

  // Bitwise update, lsb first
  always_comb begin
    next_crc = crc_o ^ {8'h00, data_i};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || clear_i) begin
      crc_o <= CRC_INIT;
    end else if (valid_i) begin
      crc_o <= next_crc;
    end
  end

endmodule

// File: hdl/mbf_follower.sv
module mbf_follower
  import mbf_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Own station address
  input  wire logic [7:0]  node_addr_i,
  // Received bytes
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_end_i,
  // Transmitted bytes
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // Holding register store
  output logic      [15:0] hr_addr_o,
  output logic      [15:0] hr_param_o,
  output logic      [3:0]  hr_word_o,
  output logic      [15:0] hr_wdata_o,
  output logic             hr_we_o,
  output logic             hr_re_o,
  input  wire logic [15:0] hr_rdata_i,
  // Coil image and applied command
  output logic      [31:0] coils_o,
  output logic      [1:0]  preset_sel_o,
  output logic             ramp_not_dcbrake_o,
  output logic             no_coast_o,
  output logic             no_quick_stop_o,
  output logic             use_ramp_o,
  output logic             start_o,
  output logic             fault_reset_o,
  output logic             jog_o,
  output logic             ramp2_o,
  output logic             relay1_o,
  output logic             relay2_o,
  output logic             setup_sel_o,
  output logic             reverse_o
);
  mbf_state_e  state;
  logic [7:0]  rx_buf [0:31];
  logic [7:0]  tx_buf [0:31];
  logic [5:0]  rx_cnt;
  logic        rx_ovf;
  logic [5:0]  idx;
  logic [5:0]  tx_len;
  logic [5:0]  tx_pos;
  logic [7:0]  tx_byte;
  logic        apply_q;
  logic        bcast_q;
  logic        reset_pulse;
  logic [15:0] drive_command_word;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  function automatic logic [4:0] word_pos(input logic [5:0] i, input logic [4:0] base);
    return base + {i[3:0], 1'b0};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Query decode
  wire logic [7:0]  f_func     = rx_buf[1];
  wire logic [15:0] f_start    = {rx_buf[2], rx_buf[3]};
  wire logic [15:0] f_qty      = {rx_buf[4], rx_buf[5]};
  wire logic [7:0]  f_bc       = rx_buf[6];
  wire logic        is_rd      = f_func == FN_RD_HR;
  wire logic        is_w1      = f_func == FN_WR_REG;
  wire logic        is_wr      = f_func == FN_WR_REGS;
  wire logic        is_wc      = f_func == FN_WR_COILS;
  wire logic        known      = is_rd | is_w1 | is_wr | is_wc;
  wire logic        bcast      = rx_buf[0] == BCAST_ADDR;
  wire logic        addr_hit   = (rx_buf[0] == node_addr_i) | bcast;
  wire logic        crc_ok     = rx_crc == 16'h0000;
  wire logic [16:0] span       = {1'b0, f_start} + {1'b0, f_qty};
  wire logic [15:0] coil_bytes = 16'((f_qty + 16'h0007) >> 3);
  wire logic [8:0]  exp_len    = (is_wc | is_wr) ? VAR_LEN + {1'b0, f_bc} : FIX_LEN;
  wire logic        len_ok     = !known || ({3'b000, rx_cnt} == exp_len);
  wire logic        qty_ok     = (f_qty != 16'h0000) && (f_qty <= MAX_REGS);

  wire logic [7:0] chk_exc =
    !known ? EX_FUNC :
    is_rd  ? (!qty_ok ? EX_VALUE : (span > HR_COUNT) ? EX_ADDR : EX_NONE) :
    is_w1  ? (({1'b0, f_start} >= HR_COUNT) ? EX_ADDR : EX_NONE) :
    is_wr  ? ((!qty_ok || f_bc != {f_qty[6:0], 1'b0}) ? EX_VALUE :
              (span > HR_COUNT) ? EX_ADDR : EX_NONE) :
    ((f_qty == 16'h0000 || {1'b0, f_qty} > COIL_COUNT || f_bc != coil_bytes[7:0])
      ? EX_VALUE : (span > COIL_COUNT) ? EX_ADDR : EX_NONE);
  // Broadcast only for executable writes; no reply path for it
  wire logic accept = crc_ok && addr_hit && len_ok && !rx_ovf && (rx_cnt >= MIN_FRAME)
                      && !(bcast && (is_rd || chk_exc != EX_NONE));

  ////////////////////////////////////////////////////////////////////////////
  // Execution datapath
  wire logic [15:0] cur_addr  = f_start + {10'h000, idx};
  wire logic        idx_last  = is_w1 || ({10'h000, idx} + 16'h0001 == f_qty);
  wire logic [7:0]  coil_src  = rx_buf[5'(DATA_POS + {2'b00, idx[5:3]})];
  wire logic        in_exec   = state == ST_EXEC;
  wire logic        send_go   = (state == ST_SEND) && tx_ready_i;
  assign hr_addr_o  = cur_addr;
  assign hr_we_o    = in_exec && (is_w1 || is_wr);
  assign hr_re_o    = in_exec && is_rd;
  assign hr_wdata_o = is_w1 ? {rx_buf[4], rx_buf[5]} :
                      {rx_buf[word_pos(idx, DATA_POS)],
                       rx_buf[word_pos(idx, DATA_POS + 5'h01)]};
  assign hr_param_o = 16'(({1'b0, cur_addr} + 17'h00001) / PNU_SCALE);
  assign hr_word_o  = 4'(({1'b0, cur_addr} + 17'h00001) % PNU_SCALE);

  assign tx_data_o  = tx_byte;
  assign tx_valid_o = state == ST_SEND;
  mbf_crc16 u_rx_crc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (state == ST_CHECK),
    .valid_i   ((state == ST_IDLE) && rx_valid_i),
    .data_i    (rx_data_i),
    .crc_o     (rx_crc)
  );
  mbf_crc16 u_tx_crc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (state == ST_CHECK),
    .valid_i   (send_go && (tx_pos < tx_len)),
    .data_i    (tx_byte),
    .crc_o     (tx_crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state   <= ST_IDLE;
      rx_cnt  <= 6'h00;
      rx_ovf  <= 1'b0;
      idx     <= 6'h00;
      tx_len  <= 6'h00;
      tx_pos  <= 6'h00;
      tx_byte <= 8'h00;
      apply_q <= 1'b0;
      bcast_q <= 1'b0;
      coils_o <= 32'h0000_0000;
    end else begin
      apply_q <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (rx_valid_i) begin
            if (rx_cnt < BUF_DEPTH) begin
              rx_buf[rx_cnt[4:0]] <= rx_data_i;
              rx_cnt <= rx_cnt + 6'h01;
            end else begin
              rx_ovf <= 1'b1;
            end
          end
          if (rx_end_i) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          rx_cnt  <= 6'h00;
          rx_ovf  <= 1'b0;
          idx     <= 6'h00;
          tx_pos  <= 6'h00;
          bcast_q <= bcast;
          if (!accept) begin
            state <= ST_IDLE;
          end else if (chk_exc != EX_NONE) begin
            tx_buf[0] <= rx_buf[0];
            tx_buf[1] <= f_func | EXC_FLAG;
            tx_buf[2] <= chk_exc;
            tx_len    <= EXC_LEN;
            state     <= ST_PREP;
          end else begin
            for (int i = 0; i < 6; i++) begin
              tx_buf[i] <= rx_buf[i];
            end
            if (is_rd) begin
              tx_buf[2] <= {f_qty[6:0], 1'b0};
              tx_len    <= RD_HDR + {f_qty[4:0], 1'b0};
            end else begin
              tx_len    <= ECHO_LEN;
            end
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (is_rd) begin
            state <= ST_RDWT;
          end else begin
            if (is_wc) begin
              coils_o[cur_addr[4:0]] <= coil_src[idx[2:0]];
            end
            idx <= idx + 6'h01;
            if (idx_last) begin
              apply_q <= is_wc;
              state   <= bcast_q ? ST_IDLE : ST_PREP;
            end
          end
        end
        ST_RDWT: begin
          tx_buf[word_pos(idx, RD_POS)]         <= hr_rdata_i[15:8];
          tx_buf[word_pos(idx, RD_POS + 5'h01)] <= hr_rdata_i[7:0];
          idx   <= idx + 6'h01;
          state <= idx_last ? ST_PREP : ST_EXEC;
        end
        ST_PREP: begin
          tx_byte <= (tx_pos < tx_len) ? tx_buf[tx_pos[4:0]] :
                     (tx_pos == tx_len) ? tx_crc[7:0] : tx_crc[15:8];
          state   <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready_i) begin
            tx_pos <= tx_pos + 6'h01;
            state  <= (tx_pos == 6'(tx_len + 6'h01)) ? ST_IDLE : ST_PREP;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      drive_command_word <= CW_RESET_VAL;
      reset_pulse        <= 1'b0;
    end else begin
      reset_pulse <= apply_q && coils_o[CW_VALID] && coils_o[CW_RESET]
                     && !drive_command_word[CW_RESET];
      if (apply_q && coils_o[CW_VALID]) begin
        drive_command_word <= coils_o[15:0];
      end
    end
  end

  assign preset_sel_o       = drive_command_word[1:0];
  assign ramp_not_dcbrake_o = drive_command_word[CW_DCB];
  assign no_coast_o         = drive_command_word[CW_COAST];
  assign no_quick_stop_o    = drive_command_word[CW_QSTOP];
  assign use_ramp_o         = drive_command_word[CW_HOLD];
  assign start_o            = drive_command_word[CW_START];
  assign fault_reset_o      = reset_pulse;
  assign jog_o              = drive_command_word[CW_JOG];
  assign ramp2_o            = drive_command_word[CW_RAMP2];
  assign relay1_o           = drive_command_word[CW_RELAY1];
  assign relay2_o           = drive_command_word[CW_RELAY2];
  assign setup_sel_o        = drive_command_word[CW_SETUP];
  assign reverse_o          = drive_command_word[CW_REV];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_on_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fault_reset_o |-> drive_command_word[CW_RESET] && !$past(drive_command_word[CW_RESET]))
    else $error("reset pulse without rising command bit");
  a_cw_valid_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(drive_command_word) |-> drive_command_word[CW_VALID] && $past(apply_q))
    else $error("command word applied without valid bit");
  a_bcast_silent: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_valid_o |-> !bcast_q)
    else $error("reply sent to broadcast");
  a_write_in_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (hr_we_o || hr_re_o) |-> ({1'b0, hr_addr_o} < HR_COUNT))
    else $error("register access beyond range");
  a_echo_after_wr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(tx_valid_o) && (tx_pos == 6'h00) && is_w1 && tx_len == ECHO_LEN |-> $past(hr_we_o, 2))
    else $error("echo before register write");
  a_read_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_PREP) && is_rd && tx_len != EXC_LEN
      |-> tx_buf[2] == {f_qty[6:0], 1'b0} && tx_len == RD_HDR + {f_qty[4:0], 1'b0})
    else $error("read byte count wrong");
  a_crc_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_CHECK) && !crc_ok |=> (state == ST_IDLE) ##1 !tx_valid_o)
    else $error("bad crc frame not dropped");
  a_coil_reply_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(tx_valid_o) && is_wc && tx_buf[1] == FN_WR_COILS |-> tx_len == ECHO_LEN)
    else $error("coil reply length wrong");

endmodule

// File: testbench/mbf_master_model.sv
module mbf_master_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Query bytes
  output logic      [7:0]  rx_data_o,
  output logic             rx_valid_o,
  output logic             rx_end_o,
  // Reply bytes
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  // Register store
  input  wire logic [15:0] hr_addr_i,
  input  wire logic [15:0] hr_param_i,
  input  wire logic [3:0]  hr_word_i,
  input  wire logic [15:0] hr_wdata_i,
  input  wire logic        hr_we_i,
  input  wire logic        hr_re_i,
  output logic      [15:0] hr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [7:0]  rsp [$];
  logic [19:0] last_loc;
  bit          slow;
  ////////////////////////////////////////
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b1;
    hr_rdata_o = 16'h0000;
    slow = 1'b0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // Reply capture and register store
  always @(posedge sys_clk_i) begin
    if (tx_valid_i && tx_ready_o) rsp.push_back(tx_data_i);
    if (hr_we_i) begin
      mem[hr_addr_i[7:0]] <= hr_wdata_i;
      last_loc <= {hr_param_i, hr_word_i};
    end
    hr_rdata_o <= hr_re_i ? mem[hr_addr_i[7:0]] : ~hr_rdata_o;
  end
  // Stalling acceptance of reply bytes
  always @(posedge sys_clk_i) begin
    #1;
    tx_ready_o = slow ? ~tx_ready_o : 1'b1;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask
  // Zero-based addresses, fields high byte first, CRC low byte first
  task automatic send(input logic [7:0] b[$], input bit bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      tick();
      rx_data_o = b[i];
      rx_valid_o = 1'b1;
      tick();
      rx_valid_o = 1'b0;
      rx_data_o = ~b[i];
    end
    tick();
    rx_end_o = 1'b1;
    tick();
    rx_end_o = 1'b0;
  endtask
endmodule

// File: testbench/mbf_follower_tb.sv
module mbf_follower_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [95:0] q; int qn; logic [63:0] r; int rn;} mbf_row_s;
  typedef logic [7:0] mbf_bytes_t [$];
  logic        sys_clk_i, rst_n_i, rx_valid_i, rx_end_i, tx_valid_o, tx_ready_i, hr_we_o;
  logic        hr_re_o, ramp_not_dcbrake_o, no_coast_o, no_quick_stop_o, use_ramp_o, start_o;
  logic        fault_reset_o, jog_o, ramp2_o, relay1_o, relay2_o, setup_sel_o, reverse_o;
  logic [1:0]  preset_sel_o;
  logic [3:0]  hr_word_o;
  logic [7:0]  rx_data_i, tx_data_o;
  logic [15:0] hr_addr_o, hr_param_o, hr_wdata_o, hr_rdata_i;
  logic [31:0] coils_o;
  int          fails, cmp_count, pulses;
  mbf_row_s    rows [8] = '{
    '{96'h01_06_03e7_0001, 6, 64'h01_06_03e7_0001, 6},
    '{96'h01_10_0407_0002_04_0000_02e2, 11, 64'h01_10_0407_0002, 6},
    '{96'h01_03_0407_0002, 6, 64'h01_03_04_0000_02e2, 7},
    '{96'h01_0f_0000_0010_02_36_af, 9, 64'h01_0f_0000_0010, 6},
    '{96'h01_03_270f_0002, 6, 64'h01_83_02, 3},
    '{96'h01_0f_001e_0003_01_07, 8, 64'h01_8f_02, 3},
    '{96'h01_04_0000_0001, 6, 64'h01_84_01, 3},
    '{96'h01_03_0000_000b, 6, 64'h01_83_03, 3}
  };
  ////////////////////////////////////////
  mbf_follower uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .node_addr_i(8'h01),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_end_i(rx_end_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .hr_addr_o(hr_addr_o), .hr_param_o(hr_param_o), .hr_word_o(hr_word_o),
    .hr_wdata_o(hr_wdata_o), .hr_we_o(hr_we_o), .hr_re_o(hr_re_o), .hr_rdata_i(hr_rdata_i),
    .coils_o(coils_o), .preset_sel_o(preset_sel_o), .ramp_not_dcbrake_o(ramp_not_dcbrake_o),
    .no_coast_o(no_coast_o), .no_quick_stop_o(no_quick_stop_o), .use_ramp_o(use_ramp_o),
    .start_o(start_o), .fault_reset_o(fault_reset_o), .jog_o(jog_o), .ramp2_o(ramp2_o),
    .relay1_o(relay1_o), .relay2_o(relay2_o), .setup_sel_o(setup_sel_o),
    .reverse_o(reverse_o)
  );
  mbf_master_model mst (
    .sys_clk_i(sys_clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
    .rx_end_o(rx_end_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .hr_addr_i(hr_addr_o), .hr_param_i(hr_param_o),
    .hr_word_i(hr_word_o), .hr_wdata_i(hr_wdata_o), .hr_we_i(hr_we_o), .hr_re_i(hr_re_o),
    .hr_rdata_o(hr_rdata_i)
  );
  ////////////////////////////////////////
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (fault_reset_o === 1'b1) pulses++;
  end
  function automatic mbf_bytes_t to_q(input logic [95:0] v, input int n);
    mbf_bytes_t b;
    for (int i = n - 1; i >= 0; i--) b.push_back(v[8*i +: 8]);
    return b;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [95:0] q, input int qn, input bit bad);
    int idle;
    idle = 0;
    mst.rsp.delete();
    mst.send(to_q(q, qn), bad);
    for (int k = 0; k < 400 && idle < 20; k++) begin
      @(posedge sys_clk_i);
      idle = (tx_valid_o === 1'b1) ? 0 : idle + 1;
    end
  endtask
  task automatic chk_rsp(input logic [63:0] r, input int rn);
    mbf_bytes_t e;
    logic [15:0] c;
    e = to_q({32'h0, r}, rn);
    c = mst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk(32'(mst.rsp.size()), 32'(e.size()));
    foreach (e[i]) if (i < mst.rsp.size()) chk({24'h0, mst.rsp[i]}, {24'h0, e[i]});
  endtask
  task automatic conclude;
    $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    conclude();
  end
  initial begin
    sys_clk_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(coils_o, 32'h0);
    chk({31'h0, tx_valid_o}, 32'h0);
    foreach (rows[i]) begin
      mst.slow = i[0];
      frame(rows[i].q, rows[i].qn, 1'b0);
      chk_rsp(rows[i].r, rows[i].rn);
    end
    chk({19'h0, preset_sel_o, ramp_not_dcbrake_o, no_coast_o, no_quick_stop_o, use_ramp_o,
         start_o, jog_o, ramp2_o, relay1_o, relay2_o, setup_sel_o, reverse_o},
        32'b1010110111011);
    chk({16'h0, mst.mem[8'he7]}, 32'h0001);
    frame(96'h01_06_0c2f_1352, 6, 1'b0);
    chk_rsp(64'h01_06_0c2f_1352, 6);
    chk({12'h0, mst.last_loc}, {12'h0, 16'h0138, 4'h0});
    frame(96'h00_0f_0010_0010_02_a5_3c, 9, 1'b0);
    chk(32'(mst.rsp.size()), 32'h0);
    chk({16'h0, coils_o[31:16]}, 32'h3ca5);
    frame(96'h01_06_0005_1234, 6, 1'b1);
    chk(32'(mst.rsp.size()), 32'h0);
    frame(96'h02_06_0005_1234, 6, 1'b0);
    chk(32'(mst.rsp.size()), 32'h0);
    chk({16'h0, mst.mem[8'h05]}, 32'h0);
    chk(pulses, 0);
    frame(96'h01_0f_0000_0010_02_80_04, 9, 1'b0);
    chk(pulses, 1);
    frame(96'h01_0f_0000_0010_02_80_04, 9, 1'b0);
    chk(pulses, 1);
    frame(96'h01_0f_0000_0010_02_00_80, 9, 1'b0);
    chk({31'h0, reverse_o}, 32'h0);
    chk({16'h0, coils_o[15:0]}, 32'h8000);
    frame(96'h01_0f_0000_0010_02_00_04, 9, 1'b0);
    frame(96'h01_0f_0000_0010_02_80_04, 9, 1'b0);
    chk(pulses, 2);
    frame(96'h01_0f_0002_0003_01_05, 8, 1'b0);
    chk_rsp(64'h01_0f_0002_0003, 6);
    chk({16'h0, coils_o[15:0]}, 32'h0494);
    chk({30'h0, preset_sel_o}, 32'h0);
    // Reset in mid-run clears coil image and command word
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(coils_o, 32'h0);
    chk({19'h0, preset_sel_o, ramp_not_dcbrake_o, no_coast_o, no_quick_stop_o, use_ramp_o,
         start_o, jog_o, ramp2_o, relay1_o, relay2_o, setup_sel_o, reverse_o}, 32'h0);
    chk({31'h0, tx_valid_o}, 32'h0);
    frame(96'h01_0f_0000_0010_02_80_04, 9, 1'b0);
    chk_rsp(64'h01_0f_0000_0010, 6);
    chk(pulses, 3);
    conclude();
  end
endmodule
